//--- pkg/trw_pkg.sv
// Constants and types for the tagged register write front end.
// Assumes a single core clock and a synchronous active-high reset.
package trw_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned TAG_W     = 9;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned TAG_LSB   = 3;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned CNT_W     = 6;

  // Register tags
  localparam logic [TAG_W-1:0] TAG_LINE_START_X   = 9'h000;
  localparam logic [TAG_W-1:0] TAG_LINE_START_Y   = 9'h001;
  localparam logic [TAG_W-1:0] TAG_LINE_STEP_X    = 9'h002;
  localparam logic [TAG_W-1:0] TAG_LINE_STEP_Y    = 9'h003;
  localparam logic [TAG_W-1:0] TAG_LINE_COUNT     = 9'h004;
  localparam logic [TAG_W-1:0] TAG_CLIP_UPPER     = 9'h005;
  localparam logic [TAG_W-1:0] TAG_PIXEL_COMBINE  = 9'h006;
  localparam logic [TAG_W-1:0] TAG_BLEND          = 9'h007;
  localparam logic [TAG_W-1:0] TAG_RENDER         = 9'h008;
  localparam logic [TAG_W-1:0] TAG_CONTINUE_LINE  = 9'h009;
  localparam logic [TAG_W-1:0] TAG_CLEAR_HIT      = 9'h00A;
  localparam logic [TAG_W-1:0] TAG_FLUSH          = 9'h00B;

  // Field widths of sign-extended coordinate fields and the line count field
  localparam int unsigned COORD_W = 16;
  localparam int unsigned COUNT_W = 16;

  localparam logic [DATA_W-1:0]  CTRL_RESET  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]   FREE_RESET  = 6'h20;

  typedef enum logic [1:0] {
    TRW_IDLE  = 2'b00,
    TRW_DRAW  = 2'b01,
    TRW_FLUSH = 2'b10
  } trw_state_e;

endpackage

//--- verilog/trw_fifo.sv
// Synchronous FIFO holding tagged register writes.
// Assumes one clock; reader and writer both live on it.
`timescale 1ns/1ps
module trw_fifo #(
  parameter int unsigned WIDTH = 41,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned CNT_W = 6
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Status
  output logic [CNT_W-1:0]      free_count
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_next;
  logic [CNT_W-1:0] used_reg;
  logic [CNT_W-1:0] used_next;
  logic [WIDTH-1:0] out_data_reg;
  logic [WIDTH-1:0] out_data_next;
  logic             out_valid_reg;
  logic             out_valid_next;
  logic             push;
  logic             pop;
  logic             load_out;

  // Storage count includes the output register stage
  assign in_ready   = (used_reg != CNT_W'(DEPTH));
  assign push       = in_valid && in_ready;
  assign load_out   = (!out_valid_reg || out_ready) && (wr_ptr_reg != rd_ptr_reg
                      || (used_reg == CNT_W'(DEPTH) && out_valid_reg == 1'b0));
  assign pop        = out_valid_reg && out_ready;
  assign out_valid  = out_valid_reg;
  assign out_data   = out_data_reg;
  assign free_count = CNT_W'(DEPTH) - used_reg;

  always_comb begin
    wr_ptr_next    = wr_ptr_reg;
    rd_ptr_next    = rd_ptr_reg;
    used_next      = used_reg;
    out_data_next  = out_data_reg;
    out_valid_next = out_valid_reg;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + PTR_W'(1);
    end
    if (pop) begin
      out_valid_next = 1'b0;
    end
    if (load_out) begin
      out_data_next  = mem[rd_ptr_reg];
      out_valid_next = 1'b1;
      rd_ptr_next    = rd_ptr_reg + PTR_W'(1);
    end
    case ({push, pop})
      2'b10:   used_next = used_reg + CNT_W'(1);
      2'b01:   used_next = used_reg - CNT_W'(1);
      default: used_next = used_reg;
    endcase
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      used_reg      <= '0;
      out_data_reg  <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg    <= wr_ptr_next;
      rd_ptr_reg    <= rd_ptr_next;
      used_reg      <= used_next;
      out_data_reg  <= out_data_next;
      out_valid_reg <= out_valid_next;
    end
  end

endmodule

//--- verilog/trw_front_end.sv
// Host write front end: queues tagged register writes and applies them.
// Assumes host writes arrive already synchronous to clk as one-cycle strobes.
`timescale 1ns/1ps
module trw_front_end #(
  parameter int unsigned FIFO_DEPTH = trw_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // Host write port inside memory region zero
  input  wire logic                           host_wr,
  input  wire logic [trw_pkg::ADDR_W-1:0]     host_addr,
  input  wire logic [3:0]                     host_be,
  input  wire logic [trw_pkg::DATA_W-1:0]     host_wdata,
  output logic                                host_wr_ready,
  output logic                                host_wr_dropped,
  // Queue status
  output logic [trw_pkg::CNT_W-1:0]           input_queue_free_count,
  // Readable control values
  output logic [trw_pkg::DATA_W-1:0]          clip_upper_limits,
  output logic [trw_pkg::DATA_W-1:0]          pixel_combine_setting,
  output logic [trw_pkg::DATA_W-1:0]          blend_setting,
  // Drawing state
  output logic                                drawing,
  output logic                                pixel_valid,
  output logic [trw_pkg::COORD_W-1:0]         pixel_x,
  output logic [trw_pkg::COORD_W-1:0]         pixel_y,
  output logic                                hit_flag,
  output logic                                flush_done
);

  localparam int unsigned ENTRY_W = trw_pkg::TAG_W + trw_pkg::DATA_W;
  localparam int unsigned CW      = trw_pkg::COORD_W;

  // ****************************************
  // Host write capture
  // ****************************************
  logic                       q_in_valid;
  logic                       q_in_ready;
  logic [ENTRY_W-1:0]         q_in_data;
  logic                       q_out_valid;
  logic                       q_out_ready;
  logic [ENTRY_W-1:0]         q_out_data;
  logic                       full_word;
  logic                       aligned;

  // Only whole 32-bit writes on a 64-bit boundary make an entry
  assign full_word  = (host_be == 4'hF);
  assign aligned    = (host_addr[trw_pkg::TAG_LSB-1:0] == 3'h0);
  assign q_in_valid = host_wr && full_word && aligned;
  // Tag is offset in 8-byte units, stored with the written word
  assign q_in_data  = {host_addr[trw_pkg::ADDR_W-1:trw_pkg::TAG_LSB], host_wdata};
  assign host_wr_ready = q_in_ready;

  // A write at a full queue is lost; a pulse lets the system observe it
  logic dropped_reg;
  logic dropped_next;
  always_comb begin
    dropped_next = host_wr && !q_in_ready;
  end

  trw_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH),
    .CNT_W (trw_pkg::CNT_W)
  ) trw_fifo_inst (
    .clk        (clk),
    .reset      (reset),
    .in_valid   (q_in_valid),
    .in_ready   (q_in_ready),
    .in_data    (q_in_data),
    .out_valid  (q_out_valid),
    .out_ready  (q_out_ready),
    .out_data   (q_out_data),
    .free_count (input_queue_free_count)
  );

  // ****************************************
  // Entry decode
  // ****************************************
  logic [trw_pkg::TAG_W-1:0]  e_tag;
  logic [trw_pkg::DATA_W-1:0] e_data;
  logic                       take;
  trw_pkg::trw_state_e        state_reg;
  trw_pkg::trw_state_e        state_next;

  assign e_tag  = q_out_data[ENTRY_W-1:trw_pkg::DATA_W];
  assign e_data = q_out_data[trw_pkg::DATA_W-1:0];
  // Entries leave one at a time in order, only while idle
  assign q_out_ready = (state_reg == trw_pkg::TRW_IDLE);
  assign take        = q_out_valid && q_out_ready;

  // ****************************************
  // Control registers
  // ****************************************
  // Bit 0 of each field is its LSB; coordinate fields keep the low bits only
  // so sign-extended words are accepted
  logic [CW-1:0]              start_x_reg, start_x_next;
  logic [CW-1:0]              start_y_reg, start_y_next;
  logic [CW-1:0]              step_x_reg, step_x_next;
  logic [CW-1:0]              step_y_reg, step_y_next;
  logic [trw_pkg::COUNT_W-1:0] count_reg, count_next;
  logic [trw_pkg::DATA_W-1:0] clip_reg, clip_next;
  logic [trw_pkg::DATA_W-1:0] combine_reg, combine_next;
  logic [trw_pkg::DATA_W-1:0] blend_reg, blend_next;

  // Only dequeued entries touch control values, never the core
  always_comb begin
    start_x_next = start_x_reg;
    start_y_next = start_y_reg;
    step_x_next  = step_x_reg;
    step_y_next  = step_y_reg;
    count_next   = count_reg;
    clip_next    = clip_reg;
    combine_next = combine_reg;
    blend_next   = blend_reg;
    if (take) begin
      case (e_tag)
        trw_pkg::TAG_LINE_START_X:  start_x_next = e_data[CW-1:0];
        trw_pkg::TAG_LINE_START_Y:  start_y_next = e_data[CW-1:0];
        trw_pkg::TAG_LINE_STEP_X:   step_x_next  = e_data[CW-1:0];
        trw_pkg::TAG_LINE_STEP_Y:   step_y_next  = e_data[CW-1:0];
        trw_pkg::TAG_LINE_COUNT:    count_next   = e_data[trw_pkg::COUNT_W-1:0];
        trw_pkg::TAG_CLIP_UPPER:    clip_next    = e_data;
        trw_pkg::TAG_PIXEL_COMBINE: combine_next = e_data;
        trw_pkg::TAG_BLEND:         blend_next   = e_data;
        default:                    clip_next    = clip_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      start_x_reg <= '0;
      start_y_reg <= '0;
      step_x_reg  <= '0;
      step_y_reg  <= '0;
      count_reg   <= '0;
      clip_reg    <= trw_pkg::CTRL_RESET;
      combine_reg <= trw_pkg::CTRL_RESET;
      blend_reg   <= trw_pkg::CTRL_RESET;
    end else begin
      start_x_reg <= start_x_next;
      start_y_reg <= start_y_next;
      step_x_reg  <= step_x_next;
      step_y_reg  <= step_y_next;
      count_reg   <= count_next;
      clip_reg    <= clip_next;
      combine_reg <= combine_next;
      blend_reg   <= blend_next;
    end
  end

  assign clip_upper_limits     = clip_reg;
  assign pixel_combine_setting = combine_reg;
  assign blend_setting         = blend_reg;

  // ****************************************
  // Working registers and line walker
  // ****************************************
  // Working registers have no tag, so no host address reaches them
  logic [CW-1:0]               work_x_reg, work_x_next;
  logic [CW-1:0]               work_y_reg, work_y_next;
  logic [trw_pkg::COUNT_W-1:0] left_reg, left_next;
  logic                        hit_reg, hit_next;
  logic                        flush_reg, flush_next;
  logic                        pix_reg, pix_next;
  logic                        in_clip;

  // Pixels beyond the clip limits are walked but not emitted
  assign in_clip = (work_x_reg <= clip_reg[CW-1:0]) && (work_y_reg <= clip_reg[31:16]);

  always_comb begin
    state_next  = state_reg;
    work_x_next = work_x_reg;
    work_y_next = work_y_reg;
    left_next   = left_reg;
    hit_next    = hit_reg;
    flush_next  = 1'b0;
    pix_next    = 1'b0;
    case (state_reg)
      trw_pkg::TRW_IDLE: begin
        if (take) begin
          case (e_tag)
            trw_pkg::TAG_RENDER: begin
              // Begin-draw reloads working values before drawing
              work_x_next = start_x_reg;
              work_y_next = start_y_reg;
              left_next   = count_reg;
              if (count_reg != '0) begin
                state_next = trw_pkg::TRW_DRAW;
              end
            end
            trw_pkg::TAG_CONTINUE_LINE: begin
              // Continue-draw keeps where the last line stopped
              left_next = count_reg;
              if (count_reg != '0) begin
                state_next = trw_pkg::TRW_DRAW;
              end
            end
            trw_pkg::TAG_CLEAR_HIT: hit_next = 1'b0;
            trw_pkg::TAG_FLUSH: state_next = trw_pkg::TRW_FLUSH;
            default: state_next = trw_pkg::TRW_IDLE;
          endcase
        end
      end
      trw_pkg::TRW_DRAW: begin
        // Coordinates follow the pixel and end on the next point
        pix_next    = in_clip;
        hit_next    = hit_reg || in_clip;
        work_x_next = work_x_reg + step_x_reg;
        work_y_next = work_y_reg + step_y_reg;
        left_next   = left_reg - trw_pkg::COUNT_W'(1);
        if (left_reg == trw_pkg::COUNT_W'(1)) begin
          state_next = trw_pkg::TRW_IDLE;
        end
      end
      trw_pkg::TRW_FLUSH: begin
        flush_next = 1'b1;
        state_next = trw_pkg::TRW_IDLE;
      end
      default: state_next = trw_pkg::TRW_IDLE;
    endcase
  end

  logic [CW-1:0] px_reg, px_next;
  logic [CW-1:0] py_reg, py_next;
  always_comb begin
    px_next = (state_reg == trw_pkg::TRW_DRAW) ? work_x_reg : px_reg;
    py_next = (state_reg == trw_pkg::TRW_DRAW) ? work_y_reg : py_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg   <= trw_pkg::TRW_IDLE;
      work_x_reg  <= '0;
      work_y_reg  <= '0;
      left_reg    <= '0;
      hit_reg     <= 1'b0;
      flush_reg   <= 1'b0;
      pix_reg     <= 1'b0;
      px_reg      <= '0;
      py_reg      <= '0;
      dropped_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      work_x_reg  <= work_x_next;
      work_y_reg  <= work_y_next;
      left_reg    <= left_next;
      hit_reg     <= hit_next;
      flush_reg   <= flush_next;
      pix_reg     <= pix_next;
      px_reg      <= px_next;
      py_reg      <= py_next;
      dropped_reg <= dropped_next;
    end
  end

  assign drawing         = (state_reg == trw_pkg::TRW_DRAW);
  assign pixel_valid     = pix_reg;
  assign pixel_x         = px_reg;
  assign pixel_y         = py_reg;
  assign hit_flag        = hit_reg;
  assign flush_done      = flush_reg;
  assign host_wr_dropped = dropped_reg;

  // ****************************************
  // Checks
  // ****************************************
  AST_FREE_MAX: assert property (@(posedge clk) disable iff (reset)
    input_queue_free_count <= trw_pkg::CNT_W'(FIFO_DEPTH))
    else $error("free count above queue depth");

  AST_DROP_FULL: assert property (@(posedge clk) disable iff (reset)
    (host_wr && !q_in_ready) |=> host_wr_dropped && input_queue_free_count
    == $past(input_queue_free_count) + trw_pkg::CNT_W'($past(take)))
    else $error("write at full queue changed the count");

  AST_FREE_DOWN: assert property (@(posedge clk) disable iff (reset)
    (q_in_valid && q_in_ready && !(q_out_valid && q_out_ready))
    |=> input_queue_free_count == $past(input_queue_free_count) - trw_pkg::CNT_W'(1))
    else $error("free count did not fall on entry");

  AST_FREE_UP: assert property (@(posedge clk) disable iff (reset)
    (!q_in_valid && q_out_valid && q_out_ready)
    |=> input_queue_free_count == $past(input_queue_free_count) + trw_pkg::CNT_W'(1))
    else $error("free count did not rise on removal");

  AST_BEGIN_LOAD: assert property (@(posedge clk) disable iff (reset)
    (take && e_tag == trw_pkg::TAG_RENDER)
    |=> work_x_reg == $past(start_x_reg) && work_y_reg == $past(start_y_reg))
    else $error("begin-draw did not load working values");

  AST_CONT_KEEP: assert property (@(posedge clk) disable iff (reset)
    (take && e_tag == trw_pkg::TAG_CONTINUE_LINE)
    |=> work_x_reg == $past(work_x_reg) && work_y_reg == $past(work_y_reg))
    else $error("continue-draw changed working values");

  AST_NO_DRAW_CMD: assert property (@(posedge clk) disable iff (reset)
    (take && (e_tag == trw_pkg::TAG_CLEAR_HIT || e_tag == trw_pkg::TAG_FLUSH))
    |=> !drawing && !pixel_valid)
    else $error("non-drawing command started a draw");

  AST_CLEAR_HIT: assert property (@(posedge clk) disable iff (reset)
    (take && e_tag == trw_pkg::TAG_CLEAR_HIT) |=> !hit_flag)
    else $error("hit flag not cleared");

  AST_CTRL_HOLD: assert property (@(posedge clk) disable iff (reset)
    !take |=> $stable(clip_reg) && $stable(blend_reg) && $stable(start_x_reg))
    else $error("control value changed without an entry");

  AST_LINE_END: assert property (@(posedge clk) disable iff (reset)
    (drawing && left_reg == trw_pkg::COUNT_W'(1))
    |=> !drawing && work_x_reg == $past(work_x_reg) + $past(step_x_reg))
    else $error("line did not end on next point");

endmodule

//--- sim/trw_host_model.sv
// Host processor model issuing register writes into the front end.
// Assumes strobes launch one small delay after the rising clock edge.
`timescale 1ns/1ps
module trw_host_model (
  // Clock
  input  wire logic                         clk,
  // Write port toward the front end
  output logic                              host_wr,
  output logic [trw_pkg::ADDR_W-1:0]        host_addr,
  output logic [3:0]                        host_be,
  output logic [trw_pkg::DATA_W-1:0]        host_wdata
);
  initial begin
    host_wr    = 1'b0;
    host_addr  = 12'hFFF;
    host_be    = 4'h0;
    host_wdata = 32'h0000_0000;
  end

  // One write per call; strobe stays up so calls may run back to back
  task automatic put(input logic [8:0] tag, input logic [31:0] data,
                     input logic [3:0] be = 4'hF, input logic [2:0] lo = 3'h0);
    host_wr    = 1'b1;
    host_addr  = {tag, lo};
    host_be    = be;
    host_wdata = data;
    @(posedge clk);
    #1;
  endtask

  // Released lines show the inverse of the last value, never a stale copy
  task automatic idle();
    host_wr    = 1'b0;
    host_addr  = ~host_addr;
    host_be    = ~host_be;
    host_wdata = ~host_wdata;
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the tagged register write front end.
// Assumes the host model drives writes and the bench watches all outputs.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  checked++; \
  if ((got) !== (ex)) begin \
    fails++; \
    $display("BAD %s exp %h got %h", nm, ex, got); \
  end \
end
module testbench;
  logic        clk, reset, host_wr, host_wr_ready, host_wr_dropped;
  logic [11:0] host_addr;
  logic [3:0]  host_be;
  logic [31:0] host_wdata, clip_upper_limits, pixel_combine_setting, blend_setting;
  logic [5:0]  input_queue_free_count;
  logic        drawing, pixel_valid, hit_flag, flush_done;
  logic [15:0] pixel_x, pixel_y;
  logic [15:0] ystep;
  logic [15:0] px[$];
  logic [15:0] py[$];
  int          fails, checked, flushes;

  // ****************************************
  // Clock, instances and output monitor
  // ****************************************
  initial clk = 1'b0;
  always #10 clk = ~clk;

  trw_host_model trw_host_model_inst (.clk(clk), .host_wr(host_wr), .host_addr(host_addr),
    .host_be(host_be), .host_wdata(host_wdata));

  trw_front_end trw_front_end_inst (.clk(clk), .reset(reset), .host_wr(host_wr),
    .host_addr(host_addr), .host_be(host_be), .host_wdata(host_wdata),
    .host_wr_ready(host_wr_ready), .host_wr_dropped(host_wr_dropped),
    .input_queue_free_count(input_queue_free_count), .clip_upper_limits(clip_upper_limits),
    .pixel_combine_setting(pixel_combine_setting), .blend_setting(blend_setting),
    .drawing(drawing), .pixel_valid(pixel_valid), .pixel_x(pixel_x), .pixel_y(pixel_y),
    .hit_flag(hit_flag), .flush_done(flush_done));

  // Pulses are registered, so reading them at the edge sees the settled value
  always @(posedge clk) begin
    if (pixel_valid === 1'b1) begin
      px.push_back(pixel_x);
      py.push_back(pixel_y);
    end
    if (flush_done === 1'b1) flushes++;
    if (input_queue_free_count > 6'h20) `CHK("free_max", 6'h20, input_queue_free_count)
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Idle must hold a few cycles: a command leaves the queue on the same edge that drawing rises
  task automatic settle();
    int n, run;
    n = 0;
    run = 0;
    while (run < 4 && n < 600) begin
      tick();
      n++;
      run = (input_queue_free_count === 6'h20 && drawing === 1'b0) ? run + 1 : 0;
    end
    if (run < 4) begin
      fails++;
      $display("BAD settle exp idle got busy");
      conclude();
    end
  endtask

  task automatic cmd(input logic [8:0] tag, input logic [31:0] data);
    trw_host_model_inst.put(tag, data);
    trw_host_model_inst.idle();
    settle();
  endtask

  task automatic expect_px(input logic [15:0] x0, input int n);
    `CHK("pix_count", n, px.size())
    for (int i = 0; i < px.size() && i < n; i++) begin
      `CHK("pix_x", x0 + 16'(i), px[i])
      `CHK("pix_y", 16'h0014 + ystep * 16'(i), py[i])
    end
    px.delete();
    py.delete();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK("free_rst", 6'h20, input_queue_free_count)
    `CHK("ready_rst", 1'b1, host_wr_ready)
    `CHK("clip_rst", 32'h0000_0000, clip_upper_limits)
    `CHK("draw_rst", 1'b0, drawing)
  endtask

  task automatic t_ctrl();
    logic [8:0]  tags [3] = '{trw_pkg::TAG_CLIP_UPPER, trw_pkg::TAG_PIXEL_COMBINE,
                              trw_pkg::TAG_BLEND};
    logic [31:0] vals [3] = '{32'h8001_7FFE, 32'hA5A5_0003, 32'h0000_0C81};
    logic [31:0] seen [3];
    for (int i = 0; i < 3; i++) begin
      trw_host_model_inst.put(tags[i], vals[i]);
      trw_host_model_inst.idle();
      `CHK("free_dec", 6'h1F, input_queue_free_count)
      seen = '{clip_upper_limits, pixel_combine_setting, blend_setting};
      `CHK("not_yet", 32'h0000_0000, seen[i])
      settle();
      seen = '{clip_upper_limits, pixel_combine_setting, blend_setting};
      `CHK("ctrl_val", vals[i], seen[i])
    end
    // Partial, misaligned and unmapped writes leave every setting alone
    trw_host_model_inst.put(trw_pkg::TAG_BLEND, 32'h1234_5678, 4'h7);
    trw_host_model_inst.put(trw_pkg::TAG_BLEND, 32'h1234_5678, 4'hF, 3'h4);
    trw_host_model_inst.put(9'h1FF, 32'h1234_5678);
    trw_host_model_inst.idle();
    settle();
    `CHK("blend_keep", vals[2], blend_setting)
    `CHK("combine_keep", vals[1], pixel_combine_setting)
  endtask

  task automatic t_draw();
    // Rasterizer values go in before the clip setting
    trw_host_model_inst.put(trw_pkg::TAG_LINE_START_X, 32'hFFFF_FFFE);
    trw_host_model_inst.put(trw_pkg::TAG_LINE_START_Y, 32'h0000_0014);
    trw_host_model_inst.put(trw_pkg::TAG_LINE_STEP_X, 32'h0000_0001);
    trw_host_model_inst.put(trw_pkg::TAG_LINE_STEP_Y, 32'h0000_0000);
    trw_host_model_inst.put(trw_pkg::TAG_LINE_COUNT, 32'h0000_0004);
    trw_host_model_inst.put(trw_pkg::TAG_CLIP_UPPER, 32'h0014_0001);
    cmd(trw_pkg::TAG_RENDER, 32'h0000_0000);
    expect_px(16'h0000, 2);
    `CHK("hit_set", 1'b1, hit_flag)
    trw_host_model_inst.put(trw_pkg::TAG_CLIP_UPPER, 32'hFFFF_FFFF);
    trw_host_model_inst.put(trw_pkg::TAG_LINE_COUNT, 32'h0000_0003);
    cmd(trw_pkg::TAG_CONTINUE_LINE, 32'h0000_0000);
    expect_px(16'h0002, 3);
    cmd(trw_pkg::TAG_RENDER, 32'h0000_0000);
    expect_px(16'hFFFE, 3);
    cmd(trw_pkg::TAG_CLEAR_HIT, 32'h0000_0000);
    expect_px(16'h0000, 0);
    `CHK("hit_clr", 1'b0, hit_flag)
    flushes = 0;
    cmd(trw_pkg::TAG_FLUSH, 32'h0000_0000);
    expect_px(16'h0000, 0);
    `CHK("flush_once", 1, flushes)
    // A zero-length line reloads but must not draw or set the hit flag
    trw_host_model_inst.put(trw_pkg::TAG_LINE_COUNT, 32'h0000_0000);
    cmd(trw_pkg::TAG_RENDER, 32'h0000_0000);
    expect_px(16'h0000, 0);
    `CHK("hit_keep", 1'b0, hit_flag)
  endtask

  task automatic t_full();
    logic        rdy;
    logic [31:0] last;
    last = pixel_combine_setting;
    ystep = 16'h0001;
    trw_host_model_inst.put(trw_pkg::TAG_LINE_STEP_Y, 32'h0000_0001);
    trw_host_model_inst.put(trw_pkg::TAG_LINE_COUNT, 32'h0000_00C8);
    trw_host_model_inst.put(trw_pkg::TAG_RENDER, 32'h0000_0000);
    for (int i = 0; i < 40; i++) begin
      rdy = host_wr_ready;
      if (rdy !== 1'b1) `CHK("free_full", 6'h00, input_queue_free_count)
      trw_host_model_inst.put(trw_pkg::TAG_PIXEL_COMBINE, 32'(i));
      `CHK("dropped", ~rdy, host_wr_dropped)
      if (rdy === 1'b1) last = 32'(i);
    end
    trw_host_model_inst.idle();
    `CHK("full_seen", 1'b0, host_wr_ready)
    settle();
    `CHK("last_kept", last, pixel_combine_setting)
    expect_px(16'hFFFE, 200);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    fails = 0;
    checked = 0;
    flushes = 0;
    ystep = 16'h0000;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_ctrl();
    t_draw();
    t_full();
    conclude();
  end
endmodule
